// ==== verilog/ubo_pkg.sv ====
`default_nettype none
package ubo_pkg;
    // bus geometry
    localparam int UBO_ADDR_W = 32;
    localparam int UBO_DATA_W = 8;
    localparam int UBO_NUM_EP = 2;
    localparam int UBO_BANK_BYTES = 64;
    localparam int UBO_CNT_W = 7;
    localparam int UBO_PTR_W = 6;

    // register offsets
    localparam logic [31:0] UBO_EP2_DATA_OFS = 32'h0020_0108;
    localparam logic [31:0] UBO_EP2_LEN_OFS = 32'h0020_010A;
    localparam logic [31:0] UBO_EP4_DATA_OFS = 32'h0020_010C;
    localparam logic [31:0] UBO_EP4_LEN_OFS = 32'h0020_010E;
    localparam logic [31:0] UBO_STATUS_OFS = 32'h0020_0120;
    localparam logic [31:0] UBO_REQ_SEL_OFS = 32'h0020_0121;
    localparam logic [31:0] UBO_NAK_EN_OFS = 32'h0020_0122;

    // field positions: endpoint index 0 is endpoint 2, index 1 is endpoint 4
    localparam int UBO_STAT_DONE_POS = 0;
    localparam int UBO_STAT_STALL_POS = 2;

    // reset values
    localparam logic [7:0] UBO_LEN_RST = 8'h00;
    localparam logic [7:0] UBO_UNMAPPED_RD = 8'h00;

    typedef enum logic [1:0] {
        UBO_RX_BYTE = 2'h0,
        UBO_RX_END_OK = 2'h1,
        UBO_RX_END_BAD = 2'h2
    } ubo_rx_kind_type;

    // one item from the serial engine
    typedef struct packed {
        logic ep;
        ubo_rx_kind_type kind;
        logic [7:0] data;
    } ubo_rx_type;

    typedef struct packed {
        logic [UBO_ADDR_W-1:0] addr;
        logic [UBO_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } ubo_bus_type;

    typedef struct packed {
        logic bankSel;
        logic [UBO_CNT_W-1:0] engCnt;
        logic engPkt;
        logic ovr;
        logic [UBO_CNT_W-1:0] cpuCnt;
        logic [UBO_PTR_W-1:0] rdPtr;
        logic [7:0] lenReg;
        logic done;
        logic stall;
        logic nakEn;
        logic sel;
        logic irqReq;
        logic dmaReq;
    } ubo_ep_type;
endpackage
`default_nettype wire

// ==== verilog/ubo_double_buffer.sv ====
// Function
// - each endpoint has two 64-byte banks, one on the engine side and one on the cpu side, swapped on toggle.
// - banks toggle only when the engine bank holds a packet and the cpu-side count is zero.
// - data and length registers are read-only bytes and writes to them do nothing.
// - received bytes for endpoint 2 or 4 go into that endpoint's engine bank without cpu help.
// - a good packet toggles the banks, sets the done flag, loads the length and raises a request.
// - a per-endpoint select bit steers the request to interrupt or dma.
// - when the length reaches zero with a good packet waiting, banks toggle and the nak-release enable clears.
// - reads past the length toggle if possible, otherwise return the first byte again.
// - overrun data while the cpu bank holds data stalls the endpoint and clears the cpu bank.
// - reading the data register with no data returns byte 0 of the cpu-side bank again, zero after reset.
// - the length register follows the received count during reception while the cpu-side count is zero.
// - an abnormal final transfer clears the length to zero when the cpu-side count is zero and raises no request.
// - each data register read while the cpu-side count is nonzero decrements the length by one.
// - endpoint 2 and endpoint 4 each get their own banks, counts and flags, fed through one shared two-entry buffer.
`timescale 1ns/1ps
`default_nettype none
module ubo_double_buffer
    import ubo_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire ubo_bus_type bus,
    output logic [UBO_DATA_W-1:0] rdata,
    input wire logic rxValid,
    input wire ubo_rx_type rxItem,
    output logic rxReady,
    output logic [UBO_NUM_EP-1:0] irqReq,
    output logic [UBO_NUM_EP-1:0] dmaReq,
    output logic [UBO_NUM_EP-1:0] rxDoneFlag,
    output logic [UBO_NUM_EP-1:0] epStall,
    output logic [UBO_NUM_EP-1:0] nakReleaseEnable
);
    typedef logic [UBO_NUM_EP-1:0][1:0][UBO_BANK_BYTES-1:0][7:0] ubo_mem_type;

    typedef struct packed {
        ubo_ep_type [UBO_NUM_EP-1:0] ep;
        ubo_mem_type mem;
        ubo_rx_type [1:0] buffer;
        logic bufWr;
        logic bufRd;
        logic [1:0] bufCnt;
        logic rxReady;
        logic [7:0] rdata;
    } ubo_state_type;

    localparam logic [UBO_CNT_W-1:0] FULL_CNT = UBO_CNT_W'(UBO_BANK_BYTES);

    ubo_state_type state_ff;
    ubo_state_type nxt_state;

    function automatic logic [31:0] data_ofs(input int e);
        data_ofs = (e == 0) ? UBO_EP2_DATA_OFS : UBO_EP4_DATA_OFS;
    endfunction

    function automatic logic [31:0] len_ofs(input int e);
        len_ofs = (e == 0) ? UBO_EP2_LEN_OFS : UBO_EP4_LEN_OFS;
    endfunction

    always_comb begin
        logic push;
        logic pop;
        logic readNow;
        logic drained;
        ubo_rx_type head;
        nxt_state = state_ff;
        push = 1'b0;
        pop = 1'b0;
        readNow = 1'b0;
        drained = 1'b0;
        head = state_ff.buffer[state_ff.bufRd];
        nxt_state.rdata = UBO_UNMAPPED_RD;

        // control registers; data and length registers ignore writes
        if (bus.wr) begin
            unique case (bus.addr)
                UBO_STATUS_OFS: begin
                    for (int e = 0; e < UBO_NUM_EP; e++) begin
                        if (bus.wdata[UBO_STAT_DONE_POS + e]) begin
                            nxt_state.ep[e].done = 1'b0;
                        end
                        if (bus.wdata[UBO_STAT_STALL_POS + e]) begin
                            nxt_state.ep[e].stall = 1'b0;
                        end
                    end
                end
                UBO_REQ_SEL_OFS: begin
                    for (int e = 0; e < UBO_NUM_EP; e++) begin
                        nxt_state.ep[e].sel = bus.wdata[e];
                    end
                end
                UBO_NAK_EN_OFS: begin
                    for (int e = 0; e < UBO_NUM_EP; e++) begin
                        nxt_state.ep[e].nakEn = bus.wdata[e];
                    end
                end
                default: begin
                end
            endcase
        end

        if (bus.rd) begin
            unique case (bus.addr)
                UBO_STATUS_OFS: begin
                    for (int e = 0; e < UBO_NUM_EP; e++) begin
                        nxt_state.rdata[UBO_STAT_DONE_POS + e] = state_ff.ep[e].done;
                        nxt_state.rdata[UBO_STAT_STALL_POS + e] = state_ff.ep[e].stall;
                    end
                end
                UBO_REQ_SEL_OFS: begin
                    for (int e = 0; e < UBO_NUM_EP; e++) begin
                        nxt_state.rdata[e] = state_ff.ep[e].sel;
                    end
                end
                UBO_NAK_EN_OFS: begin
                    for (int e = 0; e < UBO_NUM_EP; e++) begin
                        nxt_state.rdata[e] = state_ff.ep[e].nakEn;
                    end
                end
                default: begin
                end
            endcase
        end

        // buffer pop stalls while the target engine bank waits for the cpu bank to drain
        if (state_ff.bufCnt != 2'h0) begin
            pop = !state_ff.ep[head.ep].engPkt;
        end
        push = rxValid && state_ff.rxReady;

        for (int e = 0; e < UBO_NUM_EP; e++) begin
            ubo_ep_type s;
            s = nxt_state.ep[e];
            s.irqReq = 1'b0;
            s.dmaReq = 1'b0;
            drained = 1'b0;
            readNow = bus.rd && (bus.addr == data_ofs(e));
            if (bus.rd && (bus.addr == len_ofs(e))) begin
                nxt_state.rdata = s.lenReg;
            end
            if (readNow) begin
                // empty bank gives byte 0 again, stale or zero after reset
                nxt_state.rdata = state_ff.mem[e][s.bankSel][s.rdPtr];
                if (s.cpuCnt != '0) begin
                    s.cpuCnt = s.cpuCnt - UBO_CNT_W'(1);
                    s.lenReg = s.lenReg - 8'h01;
                    s.rdPtr = (s.cpuCnt == '0) ? '0 : UBO_PTR_W'(s.rdPtr + UBO_PTR_W'(1));
                    drained = (s.cpuCnt == '0);
                end
            end

            if (pop && (head.ep == e[0])) begin
                unique case (head.kind)
                    UBO_RX_BYTE: begin
                        if (s.engCnt == FULL_CNT) begin
                            s.ovr = 1'b1;
                            if (s.cpuCnt != '0) begin
                                s.stall = 1'b1;
                                s.cpuCnt = '0;
                                s.rdPtr = '0;
                                s.lenReg = UBO_LEN_RST;
                            end
                        end else begin
                            nxt_state.mem[e][!s.bankSel][s.engCnt[UBO_PTR_W-1:0]] = head.data;
                            s.engCnt = s.engCnt + UBO_CNT_W'(1);
                            if (s.cpuCnt == '0) begin
                                s.lenReg = 8'(s.engCnt);
                            end
                        end
                    end
                    UBO_RX_END_OK: begin
                        if (s.ovr) begin
                            s.engCnt = '0;
                            s.ovr = 1'b0;
                            if (s.cpuCnt == '0) begin
                                s.lenReg = UBO_LEN_RST;
                            end
                        end else begin
                            s.engPkt = 1'b1;
                        end
                    end
                    UBO_RX_END_BAD: begin
                        s.engCnt = '0;
                        s.ovr = 1'b0;
                        if (s.cpuCnt == '0) begin
                            s.lenReg = UBO_LEN_RST;
                        end
                    end
                    default: begin
                        s.engCnt = '0;
                    end
                endcase
            end

            // toggle also covers read-beyond and the drain-to-zero case
            if (s.engPkt && (s.cpuCnt == '0)) begin
                s.bankSel = !s.bankSel;
                s.cpuCnt = s.engCnt;
                s.lenReg = 8'(s.engCnt);
                s.rdPtr = '0;
                s.engCnt = '0;
                s.engPkt = 1'b0;
                s.done = 1'b1; // hardware set wins over a same-cycle clear
                s.irqReq = !s.sel;
                s.dmaReq = s.sel;
                if (drained) begin
                    s.nakEn = 1'b0;
                end
            end
            nxt_state.ep[e] = s;
        end

        // two-entry buffer between serial engine and banks
        if (push) begin
            nxt_state.buffer[state_ff.bufWr] = rxItem;
            nxt_state.bufWr = !state_ff.bufWr;
        end
        if (pop) begin
            nxt_state.bufRd = !state_ff.bufRd;
        end
        nxt_state.bufCnt = state_ff.bufCnt + 2'(push) - 2'(pop);
        nxt_state.rxReady = (nxt_state.bufCnt != 2'h2);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= '0;
            state_ff.rxReady <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rdata = state_ff.rdata;
    assign rxReady = state_ff.rxReady;

    genvar g;
    generate
        for (g = 0; g < UBO_NUM_EP; g++) begin : gen_out
            assign irqReq[g] = state_ff.ep[g].irqReq;
            assign dmaReq[g] = state_ff.ep[g].dmaReq;
            assign rxDoneFlag[g] = state_ff.ep[g].done;
            assign epStall[g] = state_ff.ep[g].stall;
            assign nakReleaseEnable[g] = state_ff.ep[g].nakEn;
        end
    endgenerate
endmodule // ubo_double_buffer
`default_nettype wire

// ==== verif/ubo_double_buffer_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module ubo_double_buffer_asserts
    import ubo_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire ubo_bus_type bus,
    input wire logic [UBO_DATA_W-1:0] rdata,
    input wire logic rxValid,
    input wire ubo_rx_type rxItem,
    input wire logic rxReady,
    input wire logic [UBO_NUM_EP-1:0] irqReq,
    input wire logic [UBO_NUM_EP-1:0] dmaReq,
    input wire logic [UBO_NUM_EP-1:0] rxDoneFlag,
    input wire logic [UBO_NUM_EP-1:0] epStall,
    input wire logic [UBO_NUM_EP-1:0] nakReleaseEnable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_rdata_idle_zero: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data present without a read");
    a_irq_one_cycle: assert property ((irqReq & $past(irqReq)) == 2'h0)
        else $error("interrupt request longer than one cycle");
    a_dma_one_cycle: assert property ((dmaReq & $past(dmaReq)) == 2'h0)
        else $error("dma request longer than one cycle");
    a_req_one_kind: assert property ((irqReq & dmaReq) == 2'h0)
        else $error("interrupt and dma request together");
    a_done_with_ep2: assert property ((irqReq[0] || dmaReq[0]) |-> ##[0:1] rxDoneFlag[0])
        else $error("endpoint 2 request without done flag");
    a_done_with_ep4: assert property ((irqReq[1] || dmaReq[1]) |-> ##[0:1] rxDoneFlag[1])
        else $error("endpoint 4 request without done flag");
    a_done_stays_set: assert property (!$past(bus.wr) |-> ($past(rxDoneFlag) & ~rxDoneFlag) == 2'h0)
        else $error("done flag dropped without a write");
    a_stall_stays_set: assert property (!$past(bus.wr) |-> ($past(epStall) & ~epStall) == 2'h0)
        else $error("stall dropped without a write");
    a_nak_clear_cause: assert property (!$past(bus.wr) |->
        (~nakReleaseEnable & $past(nakReleaseEnable) & ~(irqReq | dmaReq)) == 2'h0)
        else $error("nak-release enable cleared without a drain toggle");
    c_irq_ep2: cover property (irqReq[0]);
    c_dma_ep4: cover property (dmaReq[1]);
    c_stall_ep4: cover property (epStall[1]);
    c_rx_refused: cover property (rxValid && !rxReady);
endmodule // ubo_double_buffer_asserts

bind ubo_double_buffer ubo_double_buffer_asserts i_ubo_double_buffer_asserts (.mclk(mclk), .rst_b(rst_b),
    .bus(bus), .rdata(rdata), .rxValid(rxValid), .rxItem(rxItem), .rxReady(rxReady), .irqReq(irqReq),
    .dmaReq(dmaReq), .rxDoneFlag(rxDoneFlag), .epStall(epStall), .nakReleaseEnable(nakReleaseEnable));
`default_nettype wire

// ==== verif/ubo_sie_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ubo_sie_model
    import ubo_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic rxReady,
    output logic rxValid,
    output ubo_rx_type rxItem
);
    int nStuck = 0;
    initial begin
        rxValid = 1'b0;
        rxItem = '0;
    end
    // valid stays up across a packet so it is never lowered and raised in one step
    task automatic send(input logic ep, input int n, input logic good, input logic [7:0] base);
        for (int i = 0; i <= n; i++) begin
            rxValid <= 1'b1;
            rxItem <= '{ep, (i == n) ? (good ? UBO_RX_END_OK : UBO_RX_END_BAD) : UBO_RX_BYTE, base + 8'(i)};
            @(posedge mclk);
            for (int k = 0; k < 200 && !(rxReady && rst_b); k++) @(posedge mclk);
            // a refused item that never gets taken is counted, so the bench fails instead of hanging
            if (!(rxReady && rst_b)) nStuck++;
        end
        rxValid <= 1'b0;
        // released data toggles so a stale byte never looks valid
        rxItem.data <= ~rxItem.data;
        @(posedge mclk);
    endtask
endmodule // ubo_sie_model
`default_nettype wire

// ==== verif/ubo_double_buffer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ubo_double_buffer_tb
    import ubo_pkg::*;
;
    typedef struct {logic ep; int n; logic sel; logic [7:0] base;} ubo_row_type;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    ubo_bus_type bus = '0;
    logic [7:0] rdata, rv;
    logic rxValid, rxReady;
    ubo_rx_type rxItem;
    logic [1:0] irqReq, dmaReq, rxDoneFlag, epStall, nakReleaseEnable;
    logic [15:0] reqVec = 16'h0000;
    logic [15:0] expReq = 16'h0000;
    int nErrors = 0;
    int nCompared = 0;
    ubo_row_type rows [4] = '{'{1'b0, 1, 1'b0, 8'h10}, '{1'b1, 64, 1'b1, 8'hC0},
        '{1'b0, 3, 1'b1, 8'h20}, '{1'b1, 2, 1'b0, 8'h30}};
    always #10 mclk = ~mclk;
    // one nibble per request line: irq ep2, irq ep4, dma ep2, dma ep4
    always @(posedge mclk) reqVec <= reqVec + {3'h0, dmaReq[1], 3'h0, dmaReq[0], 3'h0, irqReq[1], 3'h0, irqReq[0]};
    ubo_double_buffer i_ubo_double_buffer (.mclk(mclk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
        .rxValid(rxValid), .rxItem(rxItem), .rxReady(rxReady), .irqReq(irqReq), .dmaReq(dmaReq),
        .rxDoneFlag(rxDoneFlag), .epStall(epStall), .nakReleaseEnable(nakReleaseEnable));
    ubo_sie_model i_ubo_sie_model (.mclk(mclk), .rst_b(rst_b), .rxReady(rxReady), .rxValid(rxValid),
        .rxItem(rxItem));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nErrors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d errors %0d", nCompared, nErrors);
        if (nErrors == 0 && nCompared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge mclk);
        bus.wr <= 1'b0;
        // one idle edge so the next strobe is never set in the step that lowers this one
        @(posedge mclk);
    endtask
    // read data stands in the cycle after the strobe; taken at the edge that ends it
    task automatic rd(input logic [31:0] a);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge mclk);
        bus.rd <= 1'b0;
        @(posedge mclk);
        rv = rdata;
    endtask
    task automatic wait_req();
        for (int k = 0; k < 50 && reqVec !== expReq; k++) @(posedge mclk);
        chk(reqVec, expReq);
    endtask
    task automatic add_req(input logic ep, input logic sel);
        expReq = expReq + (16'h1 << (4 * (2 * sel + ep)));
    endtask
    // the last read may toggle at once, so the length then shows the waiting packet
    task automatic drain(input logic ep, input logic [7:0] base, input int n, input int lastLen);
        for (int i = 0; i < n; i++) begin
            rd(UBO_EP2_DATA_OFS + 32'(4 * ep));
            chk(16'(rv), 16'(base + 8'(i)));
            rd(UBO_EP2_LEN_OFS + 32'(4 * ep));
            chk(16'(rv), 16'((i == n - 1) ? lastLen : n - 1 - i));
        end
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        chk({8'h0, rxDoneFlag, epStall, nakReleaseEnable, rxReady, 1'b0}, 16'h0002);
        wr(UBO_EP2_LEN_OFS, 8'h55);
        wr(UBO_EP2_DATA_OFS, 8'hAA);
        rd(UBO_EP2_LEN_OFS);
        chk(16'(rv), 16'(UBO_LEN_RST));
        rd(UBO_EP4_LEN_OFS);
        chk(16'(rv), 16'(UBO_LEN_RST));
        rd(32'h0020_0100);
        chk(16'(rv), 16'(UBO_UNMAPPED_RD));
        foreach (rows[r]) begin
            wr(UBO_REQ_SEL_OFS, 8'(rows[r].sel) << rows[r].ep);
            i_ubo_sie_model.send(rows[r].ep, rows[r].n, 1'b1, rows[r].base);
            add_req(rows[r].ep, rows[r].sel);
            wait_req();
            chk(16'(rxDoneFlag[rows[r].ep]), 16'h0001);
            wr(UBO_STATUS_OFS, 8'h03);
            rd(UBO_EP2_LEN_OFS + 32'(4 * rows[r].ep));
            chk(16'(rv), 16'(rows[r].n));
            drain(rows[r].ep, rows[r].base, rows[r].n, 0);
        end
        wr(UBO_REQ_SEL_OFS, 8'h00);
        i_ubo_sie_model.send(1'b0, 3, 1'b0, 8'h20);
        repeat (4) @(posedge mclk);
        chk(reqVec, expReq);
        rd(UBO_EP2_LEN_OFS);
        chk({14'h0, rxDoneFlag}, 16'h0000);
        chk(16'(rv), 16'h0000);
        wr(UBO_NAK_EN_OFS, 8'h01);
        chk(16'(nakReleaseEnable), 16'h0001);
        i_ubo_sie_model.send(1'b0, 2, 1'b1, 8'h40);
        add_req(1'b0, 1'b0);
        wait_req();
        i_ubo_sie_model.send(1'b0, 3, 1'b1, 8'h50);
        repeat (4) @(posedge mclk);
        chk(reqVec, expReq);
        fork
            i_ubo_sie_model.send(1'b0, 1, 1'b1, 8'h60);
        join_none
        repeat (6) @(posedge mclk);
        chk(16'(rxReady), 16'h0000);
        drain(1'b0, 8'h40, 2, 3);
        add_req(1'b0, 1'b0);
        wait_req();
        chk(16'(nakReleaseEnable[0]), 16'h0000);
        drain(1'b0, 8'h50, 3, 1);
        add_req(1'b0, 1'b0);
        wait_req();
        drain(1'b0, 8'h60, 1, 0);
        repeat (2) begin
            rd(UBO_EP2_DATA_OFS);
            chk(16'(rv), 16'h0060);
        end
        i_ubo_sie_model.send(1'b1, 2, 1'b1, 8'h70);
        add_req(1'b1, 1'b0);
        wait_req();
        // 65 bytes: the last one overruns the 64-byte engine bank
        i_ubo_sie_model.send(1'b1, 65, 1'b1, 8'h80);
        repeat (4) @(posedge mclk);
        chk({epStall, reqVec[13:0]}, {2'h2, expReq[13:0]});
        rd(UBO_EP4_LEN_OFS);
        chk(16'(rv), 16'h0000);
        chk(16'(i_ubo_sie_model.nStuck), 16'h0000);
        end_of_test();
    end
endmodule // ubo_double_buffer_tb
`default_nettype wire
